// File: hdl/jmic_defines.vh
`ifndef JMIC_DEFINES_VH
`define JMIC_DEFINES_VH

// register offsets
`define JMIC_ADDR_CTRL 8'h0f
`define JMIC_ADDR_X 8'h10
`define JMIC_ADDR_Y 8'h11
`define JMIC_ADDR_LEFT 8'h12
`define JMIC_ADDR_RIGHT 8'h13
`define JMIC_ADDR_TOP 8'h14
`define JMIC_ADDR_BOTTOM 8'h15

// measure_control fields
`define JMIC_BIT_IDLE 7
`define JMIC_TB_HI 6
`define JMIC_TB_LO 4
`define JMIC_BIT_IRQ_DIS 3
`define JMIC_BIT_IRQ_SRC 2
`define JMIC_BIT_SRST 1
`define JMIC_BIT_VALID 0

// reset values
`define JMIC_RST_CTRL 8'hf0
`define JMIC_RST_COORD 8'h00
`define JMIC_RST_LEFT 8'h05
`define JMIC_RST_RIGHT 8'hfb
`define JMIC_RST_TOP 8'h05
`define JMIC_RST_BOTTOM 8'hfb

// timing: reference clock and derived tick counts
`define JMIC_REF_KHZ 8000
`define JMIC_LP_UNIT_MS 20
`define JMIC_LP_UNIT_TICKS (`JMIC_LP_UNIT_MS * `JMIC_REF_KHZ)
`define JMIC_IRQ_DELAY_US 450
`define JMIC_IRQ_DELAY_TICKS ((`JMIC_IRQ_DELAY_US * `JMIC_REF_KHZ) / 1000)

// low-power period in units of 20 ms per time-base code
`define JMIC_LP_U0 5'h01
`define JMIC_LP_U1 5'h02
`define JMIC_LP_U2 5'h04
`define JMIC_LP_U3 5'h05
`define JMIC_LP_U4 5'h07
`define JMIC_LP_U5 5'h0a
`define JMIC_LP_U6 5'h0d
`define JMIC_LP_U7 5'h10

// soft reset sequence length in clk cycles
`define JMIC_SRST_CYCLES 3'h4

`endif

// File: hdl/jmic_measure_irq.v
`timescale 1ns/10ps
`include "jmic_defines.vh"

// Operation
// R1: control register resets to 1111 0000: idle, 320 ms, irq on, per-measurement.
// R2: idle bit 0 selects low-power mode with self-timed measurements.
// R3: idle bit 1 starts a measurement only after the Y-read acknowledge; the code also starts one on leaving reset or soft reset.
// R4: bits 6:4 choose one of eight low-power wake periods.
// R5: period codes map to 20, 40, 80, 100, 140, 200, 260, 320 ms.
// R6: bit 3 high holds the interrupt pin released; low drives it normally.
// R7: bit 2 low asserts the interrupt after every completed measurement.
// R8: per-measurement irq at each low-power wake, or 450 us after Y read in idle.
// R9: interrupt releases after the acknowledge following a Y register read.
// R10: bit 2 high asserts interrupt only when position leaves the dead zone.
// R11: dead-zone irq re-asserts at next measurement while still outside.
// R12: host should pair dead-zone interrupts with low-power mode.
// R13: writing 1 to bit 1 reloads every register with its reset value.
// R14: soft-reset bit returns to 0 by itself when the sequence ends.
// R15: valid bit reads 0 while a conversion is in progress.
// R16: valid bit sets once new X and Y values are stored.
// R17: pointer at 0Fh, 10h or 11h freezes control, X and Y views; the code freezes only the valid bit of control.
// R18: frozen views update only after the pointer leaves those addresses.
// R19: X at 10h and Y at 11h are signed, read-only, zero after reset.
// R20: limits left, right, top, bottom at 12h-15h reset to +5, -5, +5, -5.
// R21: outside means X above left, X below right, Y above top, Y below bottom.
// R22: wake periods and 450 us delay count ticks of the reference clock.
module jmic_measure_irq #(
  parameter LP_UNIT_TICKS = `JMIC_LP_UNIT_TICKS
) (
  input wire clk_i,
  input wire rst_i,
  input wire ref_clk_i,
  input wire [7:0] reg_ptr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire y_read_ack_i,
  input wire conv_done_i,
  input wire [7:0] conv_x_i,
  input wire [7:0] conv_y_i,
  input wire motion_irq_n_i,
  output reg [7:0] reg_rdata_o,
  output reg reg_ptr_valid_o,
  output reg meas_start_o,
  output reg motion_irq_n_o,
  output reg motion_irq_oe_o
);

  localparam ST_START = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam [7:0] RST_CTRL = `JMIC_RST_CTRL;

  ////////////////////////////////////////////////////////////////////////////////

  function [31:0] lp_ticks;
    input [2:0] code;
    reg [4:0] units;
    begin
      case (code)
        3'h0: units = `JMIC_LP_U0;
        3'h1: units = `JMIC_LP_U1;
        3'h2: units = `JMIC_LP_U2;
        3'h3: units = `JMIC_LP_U3;
        3'h4: units = `JMIC_LP_U4;
        3'h5: units = `JMIC_LP_U5;
        3'h6: units = `JMIC_LP_U6;
        default: units = `JMIC_LP_U7;
      endcase
      lp_ticks = units * LP_UNIT_TICKS; // [R5]
    end
  endfunction

  function outside_zone;
    input [7:0] x;
    input [7:0] y;
    input [7:0] lim_l;
    input [7:0] lim_r;
    input [7:0] lim_t;
    input [7:0] lim_b;
    begin
      outside_zone = ($signed(x) > $signed(lim_l)) || ($signed(x) < $signed(lim_r)) ||
                     ($signed(y) > $signed(lim_t)) || ($signed(y) < $signed(lim_b)); // [R21]
    end
  endfunction

  function is_snapshot_addr;
    input [7:0] a;
    begin
      is_snapshot_addr = (a == `JMIC_ADDR_CTRL) || (a == `JMIC_ADDR_X) || (a == `JMIC_ADDR_Y);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // reference clock synchroniser and edge finder

  reg ref_s1;
  reg ref_s2;
  reg ref_s3;
  reg ref_lvl;
  reg ref_tick;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      ref_lvl <= 1'b0;
      ref_tick <= 1'b0;
    end
    else
    begin
      ref_s1 <= ref_clk_i;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      ref_tick <= 1'b0;
      if (ref_s2 == ref_s3 && ref_s2 != ref_lvl)
      begin
        ref_lvl <= ref_s2;
        ref_tick <= ref_s2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // soft reset sequence

  reg srst_busy;
  reg [2:0] srst_cnt;
  wire wr_ctrl = reg_wr_i && !srst_busy && reg_ptr_i == `JMIC_ADDR_CTRL;
  wire soft_rst = wr_ctrl && reg_wdata_i[`JMIC_BIT_SRST];
  wire any_rst = rst_i || srst_busy;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      srst_busy <= 1'b0;
      srst_cnt <= 3'h0;
    end
    else if (soft_rst)
    begin
      srst_busy <= 1'b1; // [R13]
      srst_cnt <= `JMIC_SRST_CYCLES;
    end
    else if (srst_busy)
    begin
      srst_cnt <= srst_cnt - 3'h1;
      if (srst_cnt == 3'h1)
        srst_busy <= 1'b0; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers

  reg [7:2] ctrl;
  reg [7:0] lim_left;
  reg [7:0] lim_right;
  reg [7:0] lim_top;
  reg [7:0] lim_bottom;
  wire idle_mode = ctrl[`JMIC_BIT_IDLE];
  wire irq_src = ctrl[`JMIC_BIT_IRQ_SRC];

  always @(posedge clk_i)
  begin
    if (any_rst)
    begin
      ctrl <= RST_CTRL[7:2]; // [R1] [R13]
      lim_left <= `JMIC_RST_LEFT; // [R20]
      lim_right <= `JMIC_RST_RIGHT;
      lim_top <= `JMIC_RST_TOP;
      lim_bottom <= `JMIC_RST_BOTTOM;
    end
    else if (reg_wr_i)
    begin
      case (reg_ptr_i)
        `JMIC_ADDR_CTRL: ctrl <= reg_wdata_i[7:2];
        `JMIC_ADDR_LEFT: lim_left <= reg_wdata_i;
        `JMIC_ADDR_RIGHT: lim_right <= reg_wdata_i;
        `JMIC_ADDR_TOP: lim_top <= reg_wdata_i;
        `JMIC_ADDR_BOTTOM: lim_bottom <= reg_wdata_i;
        default: ctrl <= ctrl;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // measurement sequencer, wake timer, idle-mode irq delay

  reg [1:0] state;
  reg [31:0] lp_cnt;
  reg [31:0] dly_cnt;
  reg dly_run;
  reg [7:0] x_live;
  reg [7:0] y_live;
  reg valid_live;
  reg irq_pend;
  reg irq_set;
  wire lp_due = !idle_mode && lp_cnt >= lp_ticks(ctrl[`JMIC_TB_HI:`JMIC_TB_LO]); // [R4]
  wire idle_go = idle_mode && y_read_ack_i; // [R3]
  wire dly_due = dly_run && dly_cnt >= `JMIC_IRQ_DELAY_TICKS;

  always @*
  begin
    irq_set = 1'b0;
    if (state == ST_CONV && conv_done_i)
    begin
      if (irq_src)
        irq_set = outside_zone(conv_x_i, conv_y_i, lim_left, lim_right,
                               lim_top, lim_bottom); // [R10] [R11]
      else
        irq_set = !idle_mode; // [R7] [R8]
    end
    if (dly_due && !irq_src)
      irq_set = 1'b1; // [R8]
  end

  always @(posedge clk_i)
  begin
    if (any_rst)
    begin
      state <= ST_START;
      lp_cnt <= 32'h0000_0000;
      dly_cnt <= 32'h0000_0000;
      dly_run <= 1'b0;
      x_live <= `JMIC_RST_COORD;
      y_live <= `JMIC_RST_COORD;
      valid_live <= 1'b0;
      meas_start_o <= 1'b0;
      irq_pend <= 1'b0;
    end
    else
    begin
      meas_start_o <= 1'b0;
      if (ref_tick && !lp_due)
        lp_cnt <= lp_cnt + 32'h0000_0001; // [R22]
      if (dly_run && ref_tick && !dly_due)
        dly_cnt <= dly_cnt + 32'h0000_0001; // [R22]
      if (dly_due)
        dly_run <= 1'b0;
      case (state)
        ST_START:
        begin
          meas_start_o <= 1'b1;
          valid_live <= 1'b0;
          state <= ST_CONV;
        end
        ST_CONV:
          if (conv_done_i)
          begin
            x_live <= conv_x_i;
            y_live <= conv_y_i;
            valid_live <= 1'b1; // [R16]
            state <= ST_WAIT;
          end
        ST_WAIT:
          if (lp_due || idle_go) // [R2] [R3]
          begin
            meas_start_o <= 1'b1;
            valid_live <= 1'b0; // [R15]
            lp_cnt <= 32'h0000_0000;
            state <= ST_CONV;
          end
        default: state <= ST_START;
      endcase
      if (idle_go)
      begin
        dly_run <= 1'b1;
        dly_cnt <= 32'h0000_0000;
      end
      // a new event wins over the release in the same cycle
      if (irq_set)
        irq_pend <= 1'b1;
      else if (y_read_ack_i)
        irq_pend <= 1'b0; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // snapshot views, read data and interrupt pin

  reg [7:0] x_snap;
  reg [7:0] y_snap;
  reg valid_snap;

  always @(posedge clk_i)
  begin
    if (any_rst)
    begin
      x_snap <= `JMIC_RST_COORD; // [R19]
      y_snap <= `JMIC_RST_COORD;
      valid_snap <= 1'b0;
    end
    else if (!is_snapshot_addr(reg_ptr_i)) // [R17] [R18]
    begin
      x_snap <= x_live;
      y_snap <= y_live;
      valid_snap <= valid_live;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
      reg_ptr_valid_o <= 1'b0;
      motion_irq_n_o <= 1'b0;
      motion_irq_oe_o <= 1'b0;
    end
    else
    begin
      reg_ptr_valid_o <= reg_ptr_i >= `JMIC_ADDR_CTRL && reg_ptr_i <= `JMIC_ADDR_BOTTOM;
      case (reg_ptr_i)
        `JMIC_ADDR_CTRL: reg_rdata_o <= {ctrl, srst_busy, valid_snap}; // [R14] [R15]
        `JMIC_ADDR_X: reg_rdata_o <= x_snap;
        `JMIC_ADDR_Y: reg_rdata_o <= y_snap;
        `JMIC_ADDR_LEFT: reg_rdata_o <= lim_left;
        `JMIC_ADDR_RIGHT: reg_rdata_o <= lim_right;
        `JMIC_ADDR_TOP: reg_rdata_o <= lim_top;
        `JMIC_ADDR_BOTTOM: reg_rdata_o <= lim_bottom;
        default: reg_rdata_o <= 8'h00;
      endcase
      motion_irq_n_o <= 1'b0;
      motion_irq_oe_o <= irq_pend && !ctrl[`JMIC_BIT_IRQ_DIS] && !srst_busy; // [R6]
    end
  end

endmodule // jmic_measure_irq

// File: tb/jmic_front_model.sv
`timescale 1ns/10ps
module jmic_front_model #(
  parameter int LAT = 30
) (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] y_i,
  output logic done_o = 1'b0,
  output logic [7:0] x_o = 8'h00,
  output logic [7:0] y_o = 8'h00
);
  int cnt = 0;
  // coordinates only hold with done_o, scrambled otherwise
  always @(posedge clk_i)
  begin
    cnt <= start_i ? LAT : cnt - (cnt > 0);
    done_o <= cnt == 1;
    x_o <= cnt == 1 ? x_i : ~x_o;
    y_o <= cnt == 1 ? y_i : ~y_o;
  end
endmodule // jmic_front_model

// File: tb/jmic_measure_irq_monitor.sv
`timescale 1ns/10ps
module jmic_measure_irq_monitor #(
  parameter LP_UNIT_TICKS = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] reg_ptr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire y_read_ack_i,
  input wire conv_done_i,
  input wire [7:0] reg_rdata_o,
  input wire reg_ptr_valid_o,
  input wire meas_start_o,
  input wire motion_irq_n_o,
  input wire motion_irq_oe_o
);
  // cycles since the last write or reset, saturating
  logic [3:0] quiet;
  always @(posedge clk_i)
    quiet <= (rst_i || reg_wr_i) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ptr_valid_map: assert property (
    !$past(rst_i) |-> reg_ptr_valid_o == ($past(reg_ptr_i) >= 8'h0f && $past(reg_ptr_i) <= 8'h15))
    else $error("bad ptr valid");
  a_unmapped_zero: assert property (
    !reg_ptr_valid_o && !$past(rst_i) |-> reg_rdata_o == 8'h00)
    else $error("unmapped not zero");
  a_start_pulse: assert property (
    meas_start_o |=> !meas_start_o)
    else $error("long start");
  a_start_after_rst: assert property (
    $fell(rst_i) |=> meas_start_o)
    else $error("no start after reset");
  a_irq_cleared: assert property (
    y_read_ack_i && !conv_done_i && !$past(conv_done_i) ##1 !conv_done_i |=> !motion_irq_oe_o)
    else $error("irq kept after ack");
  a_irq_data_low: assert property (
    motion_irq_oe_o |-> !motion_irq_n_o)
    else $error("irq data high");
  a_irq_disabled: assert property (
    reg_wr_i && quiet > 4'h3 && reg_ptr_i == 8'h0f && reg_wdata_i[3] |-> ##2 !motion_irq_oe_o)
    else $error("irq not released by disable");
  a_srst_restart: assert property (
    reg_wr_i && quiet > 4'h3 && reg_ptr_i == 8'h0f && reg_wdata_i[1] |-> ##6 meas_start_o)
    else $error("no start after soft reset");
  a_snapshot_hold: assert property (
    quiet > 4'h5 && reg_ptr_i inside {8'h0f, 8'h10, 8'h11} && $stable(reg_ptr_i)
      && $past(reg_ptr_i, 2) == reg_ptr_i |=> $stable(reg_rdata_o))
    else $error("snapshot moved");
  a_limit_write: assert property (
    reg_wr_i && quiet > 4'h5 && reg_ptr_i >= 8'h12 && reg_ptr_i <= 8'h15 ##1 $stable(reg_ptr_i)
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("limit not stored");
endmodule // jmic_measure_irq_monitor

bind jmic_measure_irq jmic_measure_irq_monitor #(.LP_UNIT_TICKS(LP_UNIT_TICKS))
  i_jmic_measure_irq_monitor (.clk_i(clk_i), .rst_i(rst_i), .reg_ptr_i(reg_ptr_i),
  .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .y_read_ack_i(y_read_ack_i),
  .conv_done_i(conv_done_i), .reg_rdata_o(reg_rdata_o),
  .reg_ptr_valid_o(reg_ptr_valid_o), .meas_start_o(meas_start_o),
  .motion_irq_n_o(motion_irq_n_o), .motion_irq_oe_o(motion_irq_oe_o));

// File: tb/tb_joystick_measure_irq_control.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %h want %h", $time, (a), (e)); end end
module tb_joystick_measure_irq_control;
  logic clk_i = 1'b0, rst_i = 1'b1, ref_clk = 1'b0, wr = 1'b0, yack = 1'b0;
  logic done, start, irq_n, oe, pvalid;
  logic [7:0] ptr = 8'h20, wdata = 8'h00, fx = 8'h11, fy = 8'hee, cx, cy, rdata, d, v;
  int n_errors = 0, n_compared = 0, t;
  wire pin = oe ? irq_n : 1'b1;
  jmic_measure_irq #(.LP_UNIT_TICKS(4)) i_jmic_measure_irq (.clk_i(clk_i), .rst_i(rst_i),
    .ref_clk_i(ref_clk), .reg_ptr_i(ptr), .reg_wr_i(wr), .reg_wdata_i(wdata),
    .y_read_ack_i(yack), .conv_done_i(done), .conv_x_i(cx), .conv_y_i(cy),
    .motion_irq_n_i(pin), .reg_rdata_o(rdata), .reg_ptr_valid_o(pvalid),
    .meas_start_o(start), .motion_irq_n_o(irq_n), .motion_irq_oe_o(oe));
  jmic_front_model #(.LAT(30)) i_jmic_front_model (.clk_i(clk_i), .start_i(start),
    .x_i(fx), .y_i(fy), .done_o(done), .x_o(cx), .y_o(cy));
  //////////////////////////////////////////////////////////////////////////////
  function automatic int period(input int c);
    int u[8] = '{1, 2, 4, 5, 7, 10, 13, 16};
    return u[c] * 50;
  endfunction
  function automatic logic outside(input logic signed [7:0] x, input logic signed [7:0] y);
    return x > 8'sd5 || x < -8'sd5 || y > 8'sd5 || y < -8'sd5;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] b);
    ptr = a;
    wdata = b;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] b);
    ptr = 8'h20;
    cyc(2);
    ptr = a;
    cyc(2);
    b = rdata;
  endtask
  task automatic ack();
    yack = 1'b1;
    cyc(1);
    yack = 1'b0;
  endtask
  task automatic wait_for(input bit s, output int n);
    n = 0;
    while ((s ? oe : start) !== 1'b1 && n < 60000)
    begin
      cyc(1);
      n++;
    end
    if (n >= 60000)
    begin
      n_errors++;
      $display("MISMATCH %0t wait limit reached", $time);
    end
    cyc(1);
  endtask
  task automatic give_verdict();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    #3.3;
    forever #62.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #900_000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'hbed34c5b));
    cyc(8);
    rst_i = 1'b0;
    rd(8'h0f, d);
    `CHK(d, 8'hf0)
    rd(8'h10, d);
    `CHK(d, 8'h00)
    cyc(40);
    rd(8'h0f, d);
    `CHK(d, 8'hf1)
    rd(8'h11, d);
    `CHK(d, 8'hee)
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(8'h12 + i), d);
      `CHK(d, i[0] ? 8'hfb : 8'h05)
      v = 8'($urandom);
      wr_reg(8'(8'h12 + i), v);
      rd(8'(8'h12 + i), d);
      `CHK(d, v)
    end
    wr_reg(8'h0f, 8'h02);
    cyc(10);
    rd(8'h0f, d);
    `CHK(d, 8'hf0)
    rd(8'h12, d);
    `CHK(d, 8'h05)
    ack();
    cyc(40);
    ptr = 8'h10;
    cyc(3);
    fx = 8'h5a;
    ack();
    cyc(40);
    `CHK(rdata, 8'h11)
    rd(8'h10, d);
    `CHK(d, 8'h5a)
    ack();
    wait_for(1, t);
    `CHK(t > 44900 && t < 45100, 1'b1)
    ack();
    cyc(2);
    `CHK(oe, 1'b0)
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(8'h0f, {1'b0, c[2:0], 4'h0});
      wait_for(0, t);
      wait_for(0, t);
      `CHK(t > period(c) - 25 && t < period(c) + 25, 1'b1)
      rd(8'h0f, d);
      `CHK(d[0], 1'b0)
      cyc(40);
      `CHK(oe, 1'b1)
      ack();
    end
    fx = 8'h00;
    fy = 8'h00;
    wr_reg(8'h0f, 8'h04);
    cyc(120);
    ack();
    cyc(120);
    `CHK(oe, 1'b0)
    for (int k = 0; k < 4; k++)
    begin
      v = 8'(6 + $urandom % 100);
      fx = k == 0 ? v : (k == 1 ? -v : 8'h00);
      fy = k == 2 ? v : (k == 3 ? -v : 8'h00);
      cyc(120);
      `CHK(oe, outside(fx, fy))
      wait_for(0, t);
      cyc(35);
      ack();
      cyc(2);
      `CHK(oe, 1'b0)
      cyc(120);
      `CHK(oe, 1'b1)
    end
    wr_reg(8'h0f, 8'h0c);
    cyc(120);
    `CHK(pin, 1'b1)
    wr_reg(8'h0f, 8'h04);
    cyc(3);
    `CHK(oe, 1'b1)
    give_verdict();
  end
endmodule // tb_joystick_measure_irq_control
